// ---- src/adc_ctl_pkg.sv ----
// adc control register one: offsets, field positions, reset values, timing
// assumes a 32-bit apb slave port with one register per aligned word
package adc_ctl_pkg;
  localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h08;
  localparam logic [7:0] STATE_OFFSET = 8'h0C;
  localparam int BIT_ADDR_MODE = 12;
  localparam int BIT_BUF_EN = 11;
  localparam int BIT_WIDE = 10;
  localparam int BIT_FORM_HI = 9;
  localparam int BIT_FORM_LO = 8;
  localparam int BIT_TRIG_HI = 7;
  localparam int BIT_TRIG_LO = 4;
  localparam int BIT_UNUSED3 = 3;
  localparam int BIT_AUTO = 2;
  localparam int BIT_ACQ = 1;
  localparam int BIT_DONE = 0;
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h1FF6;
  localparam logic [3:0] TRIG_MANUAL = 4'h0;
  localparam logic [3:0] TRIG_EXT_INTERRUPT_ZERO = 4'h1;
  localparam logic [3:0] TRIG_TIMER_THREE_EVENT = 4'h2;
  localparam logic [3:0] TRIG_TIMER_FIVE_EVENT = 4'h3;
  localparam logic [3:0] TRIG_CHARGE_TIME_UNIT_EVENT = 4'h4;
  localparam logic [3:0] TRIG_TIMER_ONE_EVENT = 4'h5;
  localparam logic [3:0] TRIG_AUTO = 4'h7;
  localparam logic [1:0] FORM_UINT = 2'h0;
  localparam logic [1:0] FORM_SINT = 2'h1;
  localparam logic [1:0] FORM_UFRAC = 2'h2;
  localparam logic [1:0] FORM_SFRAC = 2'h3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BAD_TRIG = 1;
  localparam int IRQ_WIDTH = 2;
  localparam int CONV_CYCLES_10 = 12;
  localparam int CONV_CYCLES_12 = 14;
  localparam int AUTO_SAMPLE_CYCLES = 16;
endpackage : adc_ctl_pkg

// ---- src/adc_trig_sel.sv ----
// trigger selector: picks the end-of-sample event by trigger code
// assumes event inputs are already synchronous one-cycle pulses
`timescale 1ns/1ps
module adc_trig_sel
  import adc_ctl_pkg::*;
(
  input wire logic [3:0] i_sel,
  input wire logic i_ext_interrupt_zero,
  input wire logic i_timer_one_event,
  input wire logic i_timer_three_event,
  input wire logic i_timer_five_event,
  input wire logic i_charge_time_unit_event,
  input wire logic i_auto_done,
  output logic o_trig,
  output logic o_illegal
);
  always_comb begin
    o_illegal = 1'b0;
    unique case (i_sel)
      TRIG_EXT_INTERRUPT_ZERO: o_trig = i_ext_interrupt_zero;
      TRIG_TIMER_THREE_EVENT: o_trig = i_timer_three_event;
      TRIG_TIMER_FIVE_EVENT: o_trig = i_timer_five_event;
      TRIG_CHARGE_TIME_UNIT_EVENT: o_trig = i_charge_time_unit_event;
      TRIG_TIMER_ONE_EVENT: o_trig = i_timer_one_event;
      TRIG_AUTO: o_trig = i_auto_done;
      TRIG_MANUAL: o_trig = 1'b0;
      default: begin
        // unused and top-bit codes never trigger
        o_trig = 1'b0;
        o_illegal = 1'b1;
      end
    endcase
  end
endmodule : adc_trig_sel

// ---- src/adc_fmt.sv ----
// result formatter: 10 or 12 bit raw code to 16-bit output word
// assumes raw code sits in the low bits of i_raw
`timescale 1ns/1ps
module adc_fmt
  import adc_ctl_pkg::*;
(
  input wire logic [11:0] i_raw,
  input wire logic i_wide,
  input wire logic [1:0] i_form,
  output logic [15:0] o_word
);
  logic [11:0] code;
  logic [11:0] signed_code;
  always_comb begin
    code = i_wide ? i_raw : {2'h0, i_raw[9:0]};
    // signed forms are offset binary with the midscale bit flipped
    signed_code = i_wide ? {~code[11], code[10:0]} : {2'h0, ~code[9], code[8:0]};
    unique case (i_form)
      FORM_UINT: o_word = {4'h0, code};
      FORM_SINT: o_word = i_wide ? {{4{signed_code[11]}}, signed_code}
                                 : {{6{signed_code[9]}}, signed_code[9:0]};
      FORM_UFRAC: o_word = i_wide ? {code, 4'h0} : {code[9:0], 6'h00};
      FORM_SFRAC: o_word = i_wide ? {signed_code, 4'h0}
                                  : {signed_code[9:0], 6'h00};
    endcase
  end
endmodule : adc_fmt

// ---- src/adc_control_one.sv ----
// adc control register one with sample/convert sequencer and apb slave
// assumes trigger pulses and raw data are synchronous to I_CORE_CLK
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
// Function
// - buffer enable turns on extended buffer features
// - wide select picks 12-bit else 10-bit
// - formats 11/10 give left-justified fractions
// - formats 01/00 give right-justified integers
// - code 0111 auto-converts after internal count
// - bits 7:4 select trigger event source
// - code 0000 converts when software clears acquire
// - auto start restarts acquire after conversion
// - acquire bit shows sampling versus holding
// - done bit set after conversion, else zero
// - address mode works only with buffer enable
// - bit 3 reads zero, ignores writes
// - address mode selects destination or controller source
module adc_control_one
  import adc_ctl_pkg::*;
#(
  parameter int CONV_10 = CONV_CYCLES_10,
  parameter int CONV_12 = CONV_CYCLES_12,
  parameter int AUTO_SAMPLE = AUTO_SAMPLE_CYCLES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic I_TIMER_ONE_EVENT,
  input wire logic I_TIMER_THREE_EVENT,
  input wire logic I_TIMER_FIVE_EVENT,
  input wire logic I_CHARGE_TIME_UNIT_EVENT,
  input wire logic I_EXT_INTERRUPT_ZERO,
  input wire logic [11:0] I_RAW_DATA,
  output logic [15:0] O_RESULT,
  output logic O_RESULT_VALID,
  output logic O_EXT_BUFFER_ON,
  output logic O_ADDR_FROM_DEST,
  output logic O_SAMPLING,
  output logic O_IRQ
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} seq_t;

  logic [15:0] ctrl, next_ctrl;
  logic [IRQ_WIDTH-1:0] irq_status, next_irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
  seq_t state, next_state;
  logic [7:0] count, next_count;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic [15:0] result, next_result;
  logic result_valid, next_result_valid;
  logic irq, next_irq;
  logic buf_on, next_buf_on;
  logic from_dest, next_from_dest;

  logic wr, rd, trig, illegal, auto_done, conv_end;
  logic [3:0] trig_sel;
  logic [15:0] fmt_word;
  logic [7:0] conv_len;

  // two-phase apb slave answering in the second access cycle, after one wait state
  assign wr = i_psel && i_penable && i_pwrite && !pready;
  assign rd = i_psel && i_penable && !i_pwrite && !pready;
  assign trig_sel = ctrl[BIT_TRIG_HI:BIT_TRIG_LO];
  assign auto_done = (state == ST_ACQ) && (count == 8'(AUTO_SAMPLE - 1));
  assign conv_len = ctrl[BIT_WIDE] ? 8'(CONV_12) : 8'(CONV_10);
  assign conv_end = (state == ST_CONV) && (count == conv_len - 8'h01);

  adc_trig_sel u_trig (
    .i_sel(trig_sel),
    .i_ext_interrupt_zero(I_EXT_INTERRUPT_ZERO),
    .i_timer_one_event(I_TIMER_ONE_EVENT),
    .i_timer_three_event(I_TIMER_THREE_EVENT),
    .i_timer_five_event(I_TIMER_FIVE_EVENT),
    .i_charge_time_unit_event(I_CHARGE_TIME_UNIT_EVENT),
    .i_auto_done(auto_done),
    .o_trig(trig),
    .o_illegal(illegal)
  );

  adc_fmt u_fmt (
    .i_raw(I_RAW_DATA),
    .i_wide(ctrl[BIT_WIDE]),
    .i_form(ctrl[BIT_FORM_HI:BIT_FORM_LO]),
    .o_word(fmt_word)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_count = count;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    next_result = result;
    next_result_valid = 1'b0;
    if (i_psel && i_penable && !pready) begin
      next_pready = 1'b1;
    end
    if (wr) begin
      unique case (i_paddr)
        CTRL_ONE_OFFSET: begin
          // bit 3 and done are not plain storage
          next_ctrl = (ctrl & ~CTRL_WRITE_MASK) | (i_pwdata[15:0] & CTRL_WRITE_MASK);
          if (!i_pwdata[BIT_DONE]) begin
            next_ctrl[BIT_DONE] = 1'b0;
          end
        end
        IRQ_STATUS_OFFSET: next_irq_status = irq_status & ~i_pwdata[IRQ_WIDTH-1:0];
        IRQ_MASK_OFFSET: next_irq_mask = i_pwdata[IRQ_WIDTH-1:0];
        STATE_OFFSET: next_pslverr = 1'b1;
        default: next_pslverr = 1'b1;
      endcase
    end else if (rd) begin
      unique case (i_paddr)
        CTRL_ONE_OFFSET: next_prdata = {16'h0000, ctrl};
        IRQ_STATUS_OFFSET: next_prdata = {30'h0, irq_status};
        IRQ_MASK_OFFSET: next_prdata = {30'h0, irq_mask};
        STATE_OFFSET: next_prdata = {22'h0, count, state};
        default: next_pslverr = 1'b1;
      endcase
    end
    // sequencer follows the acquire bit as software left it
    unique case (state)
      ST_IDLE: begin
        next_count = 8'h00;
        if (next_ctrl[BIT_ACQ]) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        next_count = count + 8'h01;
        if (trig || (trig_sel == TRIG_MANUAL && !next_ctrl[BIT_ACQ])) begin
          next_state = ST_CONV;
          next_count = 8'h00;
          next_ctrl[BIT_ACQ] = 1'b0;
          next_ctrl[BIT_DONE] = 1'b0;
        end else if (!next_ctrl[BIT_ACQ]) begin
          next_state = ST_IDLE;
        end
      end
      ST_CONV: begin
        next_count = count + 8'h01;
        next_ctrl[BIT_ACQ] = 1'b0;
        if (conv_end) begin
          next_count = 8'h00;
          next_ctrl[BIT_DONE] = 1'b1;
          next_result = fmt_word;
          next_result_valid = 1'b1;
          if (ctrl[BIT_AUTO]) begin
            next_ctrl[BIT_ACQ] = 1'b1;
            next_state = ST_ACQ;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
    endcase
    // set wins over a same-cycle clear
    if (conv_end) begin
      next_irq_status[IRQ_DONE] = 1'b1;
    end
    if (illegal) begin
      next_irq_status[IRQ_BAD_TRIG] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
    next_buf_on = next_ctrl[BIT_BUF_EN];
    next_from_dest = next_ctrl[BIT_BUF_EN] && next_ctrl[BIT_ADDR_MODE];
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ctrl <= CTRL_ONE_RESET;
      state <= ST_IDLE;
      count <= 8'h00;
      irq_status <= '0;
      irq_mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      result <= 16'h0000;
      result_valid <= 1'b0;
      irq <= 1'b0;
      buf_on <= 1'b0;
      from_dest <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      state <= next_state;
      count <= next_count;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      result <= next_result;
      result_valid <= next_result_valid;
      irq <= next_irq;
      buf_on <= next_buf_on;
      from_dest <= next_from_dest;
    end
  end

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign O_RESULT = result;
  assign O_RESULT_VALID = result_valid;
  assign O_EXT_BUFFER_ON = buf_on;
  assign O_ADDR_FROM_DEST = from_dest;
  assign O_SAMPLING = ctrl[BIT_ACQ];
  assign O_IRQ = irq;

  // cycles spent converting; a counter stands in for a long repetition the tools would unroll
  logic [7:0] conv_run, next_conv_run;

  always_comb begin
    next_conv_run = 8'h00;
    if (state == ST_CONV) begin
      next_conv_run = conv_run + 8'h01;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      conv_run <= 8'h00;
    end else begin
      conv_run <= next_conv_run;
    end
  end

  a_bit3_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    ctrl[BIT_UNUSED3] == 1'b0) else $error("bit 3 not zero");
  a_addr_mode_gate: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    from_dest |-> buf_on) else $error("address mode without enable");
  a_buf_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    buf_on == ctrl[BIT_BUF_EN]) else $error("buffer enable mismatch");
  a_done_on_end: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    conv_end |=> ctrl[BIT_DONE] && result_valid) else $error("done not set");
  a_done_low_conv: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (state == ST_CONV) |-> !ctrl[BIT_DONE]) else $error("done high in conversion");
  a_acq_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (state == ST_CONV) |-> !ctrl[BIT_ACQ]) else $error("acquire high while holding");
  a_auto_restart: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    conv_end && ctrl[BIT_AUTO] |=> ctrl[BIT_ACQ] && state == ST_ACQ)
    else $error("no auto restart");
  a_no_restart: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    conv_end && !ctrl[BIT_AUTO] |=> state == ST_IDLE) else $error("restart without auto");
  a_auto_count: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (trig_sel == TRIG_AUTO && state == ST_ACQ && $past(state) != ST_ACQ && ctrl[BIT_ACQ])
    |-> ##[1:300] state == ST_CONV) else $error("auto convert missing");
  a_conv_len: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $fell(state == ST_CONV) |-> conv_run == conv_len)
    else $error("conversion length wrong");
  a_pready_one: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    pready |=> !pready) else $error("pready longer than one cycle");
  // sequencer starts, bad codes, irq level, result pulse, acquire, address source and bus answers
  a_manual_start: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    state == ST_ACQ && trig_sel == TRIG_MANUAL && wr && i_paddr == CTRL_ONE_OFFSET
    && !i_pwdata[BIT_ACQ] |=> state == ST_CONV) else $error("manual start missing");
  a_trig_start: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    state == ST_ACQ && trig |=> state == ST_CONV) else $error("trigger ignored");
  a_bad_code: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    illegal |-> !trig ##1 irq_status[IRQ_BAD_TRIG])
    else $error("bad code not flagged");
  a_irq_level: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    irq == |(irq_status & irq_mask)) else $error("irq not level of status and mask");
  a_valid_pulse: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    result_valid |=> !result_valid) else $error("result valid longer than one cycle");
  a_err_with_ready: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    pslverr |-> pready) else $error("slave error without ready");
  a_acq_sampling: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    state == ST_ACQ |-> ctrl[BIT_ACQ]) else $error("acquire low while sampling");
  a_prdata_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
  a_dest_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    from_dest == (ctrl[BIT_BUF_EN] && ctrl[BIT_ADDR_MODE]))
    else $error("address source mismatch");
  a_ready_answer: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    i_psel && i_penable && !pready |=> pready) else $error("no answer to access");
  c_manual: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    trig_sel == TRIG_MANUAL && conv_end);
  c_auto: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    trig_sel == TRIG_AUTO && conv_end && ctrl[BIT_AUTO]);
  c_timer: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    trig_sel == TRIG_TIMER_ONE_EVENT && trig && state == ST_ACQ);
  c_irq: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) $rose(irq));
  c_bad_code: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    illegal && irq_status[IRQ_BAD_TRIG]);
endmodule : adc_control_one

// ---- bench/testbench.sv ----
// self-checking bench for adc control register one: apb access, conversions, irq
// assumes the apb slave answers with a one-cycle pready and the package constants
`timescale 1ns/1ps
module testbench;
  import adc_ctl_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic res_valid, buf_on, from_dest, sampling, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] ev;
  logic [11:0] raw;
  logic [15:0] result, lfsr;
  logic [15:0] vals [3] = '{16'h1000, 16'h1800, 16'h0800};
  int failures, comparisons, cycles;

  adc_control_one u_adc_control_one (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .I_TIMER_ONE_EVENT(ev[4]),
    .I_TIMER_THREE_EVENT(ev[1]), .I_TIMER_FIVE_EVENT(ev[2]),
    .I_CHARGE_TIME_UNIT_EVENT(ev[3]), .I_EXT_INTERRUPT_ZERO(ev[0]),
    .I_RAW_DATA(raw), .O_RESULT(result), .O_RESULT_VALID(res_valid),
    .O_EXT_BUFFER_ON(buf_on), .O_ADDR_FROM_DEST(from_dest),
    .O_SAMPLING(sampling), .O_IRQ(irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand

  // signed forms are offset binary minus midscale; fractions shift to the top
  function automatic logic [15:0] model_fmt(input logic [11:0] r, input logic w,
                                            input logic [1:0] f);
    int n;
    int v;
    n = w ? 12 : 10;
    v = int'(r) & ((1 << n) - 1);
    if (f[0]) v = v - (1 << (n - 1));
    if (f[1]) v = v << (16 - n);
    return v[15:0];
  endfunction : model_fmt

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask : chk

  // the request stands until pready is seen high at a rising edge; data is taken there
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d);
    chk("write error", 32'(e), 32'(err));
  endtask : wchk

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk("read data", exp, rd);
    chk("read error", 32'h0, 32'(err));
  endtask : rchk

  task automatic conv(input logic [3:0] code, input logic w, input logic [1:0] f,
                      input logic au);
    logic [15:0] c;
    int n;
    lfsr = next_rand(lfsr);
    raw <= lfsr[11:0];
    c = {5'h00, w, f, code, 1'b0, au, 2'b00};
    wchk(CTRL_ONE_OFFSET, {16'h0000, c | 16'h0002}, 1'b0);
    @(negedge clk);
    chk("sampling", 32'h1, 32'(sampling));
    if (code != TRIG_MANUAL && code != TRIG_AUTO) begin
      @(posedge clk);
      ev <= ~(5'h01 << (code - 4'h1));
      @(posedge clk);
      ev <= 5'h00;
      repeat (2) @(negedge clk);
      chk("foreign event", 32'h1, 32'(sampling));
      @(posedge clk);
      ev <= 5'h01 << (code - 4'h1);
      @(posedge clk);
      ev <= 5'h00;
    end
    if (code == TRIG_MANUAL) wchk(CTRL_ONE_OFFSET, {16'h0000, c}, 1'b0);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (res_valid !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    chk("result", {16'h0000, model_fmt(raw, w, f)}, {16'h0000, result});
    rchk(CTRL_ONE_OFFSET, {16'h0000, c | {14'h0000, au, 1'b1}});
    wchk(CTRL_ONE_OFFSET, {16'h0000, c}, 1'b0);
    rchk(CTRL_ONE_OFFSET, {16'h0000, c});
  endtask : conv

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 5'h00;
    raw = 12'h000;
    rst_n = 1'b0;
    lfsr = 16'h003E;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(CTRL_ONE_OFFSET, {16'h0000, CTRL_ONE_RESET});
    rchk(IRQ_MASK_OFFSET, 32'h0);
    acc(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    wchk(STATE_OFFSET, 32'h3, 1'b1);
    $display("test registers finished");
    for (int i = 0; i < 3; i++) begin
      wchk(CTRL_ONE_OFFSET, {16'h0000, vals[i] | 16'h0008}, 1'b0);
      @(negedge clk);
      chk("buffer on", 32'(vals[i][11]), 32'(buf_on));
      chk("addr from dest", 32'(vals[i][12] & vals[i][11]), 32'(from_dest));
      rchk(CTRL_ONE_OFFSET, {16'h0000, vals[i]});
    end
    wchk(CTRL_ONE_OFFSET, 32'h0, 1'b0);
    $display("test control bits finished");
    for (int k = 0; k < 8; k++) conv(TRIG_MANUAL, k[2], k[1:0], 1'b0);
    for (int k = 1; k < 6; k++) conv(k[3:0], lfsr[0], lfsr[2:1], 1'b0);
    conv(TRIG_AUTO, 1'b1, FORM_SFRAC, 1'b1);
    $display("test conversions finished");
    wchk(IRQ_STATUS_OFFSET, 32'h3, 1'b0);
    wchk(IRQ_MASK_OFFSET, 32'h1, 1'b0);
    @(negedge clk);
    chk("irq idle", 32'h0, 32'(irq));
    conv(TRIG_MANUAL, 1'b0, FORM_UINT, 1'b0);
    chk("irq raised", 32'h1, 32'(irq));
    rchk(IRQ_STATUS_OFFSET, 32'h1);
    wchk(IRQ_STATUS_OFFSET, 32'h1, 1'b0);
    @(negedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    wchk(CTRL_ONE_OFFSET, 32'h0060, 1'b0);
    @(negedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    rchk(IRQ_STATUS_OFFSET, 32'h2);
    wchk(CTRL_ONE_OFFSET, 32'h0, 1'b0);
    wchk(IRQ_STATUS_OFFSET, 32'h3, 1'b0);
    rchk(IRQ_STATUS_OFFSET, 32'h0);
    $display("test interrupts finished");
    print_verdict();
  end
endmodule : testbench
